// [core/pfid_pkg.sv]
/*
  package for the partition feature identification register bank:
  offsets, field positions, frame codes and encodings.
  assumes a simple memory-mapped read/write port in front of the bank.
*/
package pfid_pkg;

  // register byte offsets within each feature-page frame
  localparam logic [11:0] ARCH_REV_OFFSET  = 12'h020;
  localparam logic [11:0] CAP_FEAT_OFFSET  = 12'h038;

  // security frames, gray order along the usual walk
  typedef enum logic [1:0]
  {
    PFID_FRAME_SECURE    = 2'h0,
    PFID_FRAME_NONSECURE = 2'h1,
    PFID_FRAME_ROOT      = 2'h3,
    PFID_FRAME_FOURTH    = 2'h2
  } pfid_frame_type;

  localparam int NUM_FRAMES = 4;

  // revision byte encodings
  localparam logic [7:0] REV_0P1 = 8'h01;
  localparam logic [7:0] REV_1P0 = 8'h10;
  localparam logic [7:0] REV_1P1 = 8'h11;

  // revision field positions
  localparam int REV_MAJOR_LSB = 4;
  localparam int REV_MINOR_LSB = 0;

  // capacity feature field positions
  localparam int CAP_SOFTLIM_BIT  = 31;
  localparam int CAP_MAXABS_BIT   = 30;
  localparam int CAP_MINPRES_BIT  = 29;
  localparam int CAP_ASSOC_BIT    = 28;
  localparam int CAP_ASSOC_WD_LSB = 8;
  localparam int CAP_MAX_WD_LSB   = 0;

  // capacity fraction bit limits
  localparam int CAP_MAX_WD_MIN = 1;
  localparam int CAP_MAX_WD_MAX = 16;

  // read data after reset
  localparam logic [31:0] RDATA_RESET = 32'h0000_0000;

endpackage

// [core/pfid_rev_word.sv]
/*
  builds the architecture revision word from a revision byte.
  assumes the byte was checked at elaboration by the parent.
*/
`timescale 1ns/100ps
module pfid_rev_word
(
  input  wire logic [7:0]  rev_byte_i,
  output logic      [31:0] word_o
);

  // upper bits reserved, read zero
  assign word_o = {24'h00_0000, rev_byte_i[7:4], rev_byte_i[3:0]}; // see RULE_16 see RULE_18

endmodule

// [core/pfid_cap_word.sv]
/*
  builds one cache capacity feature word from its loose fields.
  assumes fields come from the selected resource instance.
*/
`timescale 1ns/100ps
module pfid_cap_word
(
  input  wire logic       softlim_i,
  input  wire logic       max_absent_i,
  input  wire logic       min_present_i,
  input  wire logic       assoc_present_i,
  input  wire logic [4:0] assoc_wd_i,
  input  wire logic [5:0] max_wd_i,
  output logic      [31:0] word_o
);

  assign word_o = {softlim_i,           // see RULE_09
                   max_absent_i,        // see RULE_10
                   min_present_i,       // see RULE_11
                   assoc_present_i,     // see RULE_12
                   15'h0000,            // see RULE_18
                   assoc_wd_i,          // see RULE_13
                   2'h0,                // see RULE_18
                   max_wd_i};           // see RULE_14

endmodule

// [core/pfid_regs.sv]
/*
  read-only feature identification registers, one copy per security frame.
  holds the revision word, shared by all frames, and one cache capacity
  feature word per frame, built from that frame's own field slice.
  assumes a single-cycle register port from the host component:
  frame code, byte offset, read and write strobes; data answers next cycle.
  frame codes: 0 secure, 1 nonsecure, 3 root, 2 fourth space.
  resource instance fields arrive as per-instance vectors,
  indexed by frame code times instance count plus instance.
  assumes the field inputs are static straps with fraction counts in range.
*/
// Function
// RULE_01 - revision register readable in all four frames
// RULE_02 - revision contents identical in every frame
// RULE_03 - revision register at offset 0x20, read-only
// RULE_04 - root and fourth frames read-only when present
// RULE_05 - separate readable capacity register per frame
// RULE_06 - capacity copies may differ between frames
// RULE_07 - capacity register at offset 0x38, read-only
// RULE_08 - capacity register reads zero unless present
// RULE_09 - bit 31 soft limit select present
// RULE_10 - bit 30 capacity maximum control absent
// RULE_11 - bit 29 capacity minimum control present
// RULE_12 - bit 28 associativity maximum control present
// RULE_13 - bits 12:8 associativity fraction bit count
// RULE_14 - bits 5:0 capacity fraction bits 1..16
// RULE_15 - instance fields follow selected resource instance
// RULE_16 - major bits 7:4, minor bits 3:0
// RULE_17 - revision byte only 0x01, 0x10, 0x11
// RULE_18 - reserved bits read zero
// RULE_19 - writes ignored, values unchanged
`timescale 1ns/100ps
module pfid_regs
#(
  parameter logic [7:0] REV_BYTE      = pfid_pkg::REV_1P1,
  parameter int         NUM_INST      = 1,
  parameter int         INST_W        = 1,
  parameter bit         BASE_REVISION = 1'b0
)
(
  input  wire logic                      clk_i,
  input  wire logic                      rst_n_i,

  // register port
  input  wire logic [1:0]                frame_i,
  input  wire logic [11:0]               addr_i,
  input  wire logic                      rd_i,
  input  wire logic                      wr_i,
  input  wire logic [31:0]               wdata_i,

  // configuration straps
  input  wire logic                      capacity_partitioning_present_i,
  input  wire logic                      fourth_space_feature_i,
  input  wire logic                      instance_selector_supported_i,
  input  wire logic [INST_W-1:0]         resource_instance_select_i,

  // per-instance capacity fields
  input  wire logic [4*NUM_INST-1:0]     capacity_softlimit_present_i,
  input  wire logic [4*NUM_INST-1:0]     capacity_max_absent_i,
  input  wire logic [4*NUM_INST-1:0]     capacity_min_present_i,
  input  wire logic [4*NUM_INST-1:0]     associativity_max_present_i,
  input  wire logic [4*NUM_INST*5-1:0]   associativity_fraction_bits_i,
  input  wire logic [4*NUM_INST*6-1:0]   capacity_fraction_bits_i,

  // registered answer
  output logic      [31:0]               rdata_o,
  output logic                           rvalid_o
);

  //////////////////////////////////////////////////////////////////////////////
  // elaboration checks

  // settings the decode cannot serve are refused here
  if (!(REV_BYTE == pfid_pkg::REV_0P1 ||
        REV_BYTE == pfid_pkg::REV_1P0 ||
        REV_BYTE == pfid_pkg::REV_1P1)) // see RULE_17
  begin : g_bad_rev
    $error("unsupported revision byte");
  end

  if (NUM_INST < 1)
  begin : g_no_inst
    $error("at least one resource instance is needed");
  end

  if (INST_W < 1 || INST_W > 16)
  begin : g_bad_sel_w
    $error("instance selector width out of range");
  end

  if ((1 << INST_W) < NUM_INST)
  begin : g_sel_narrow
    $error("instance selector too narrow");
  end

  // the frame decode below has exactly four arms
  if (pfid_pkg::NUM_FRAMES != 4)
  begin : g_frame_cnt
    $error("frame count must be four");
  end

  // offsets must be word aligned and distinct
  if ((pfid_pkg::ARCH_REV_OFFSET & 12'h003) != 12'h000 ||
      (pfid_pkg::CAP_FEAT_OFFSET & 12'h003) != 12'h000 ||
      pfid_pkg::ARCH_REV_OFFSET == pfid_pkg::CAP_FEAT_OFFSET)
  begin : g_bad_offs
    $error("register offsets clash or are unaligned");
  end

  //////////////////////////////////////////////////////////////////////////////
  // revision word, one builder shared by all frames

  logic [31:0] rev_word;

  pfid_rev_word u_rev
  (
    .rev_byte_i (REV_BYTE),
    .word_o     (rev_word)
  );

  //////////////////////////////////////////////////////////////////////////////
  // instance select: fixed to zero when the selector is not supported

  logic [INST_W-1:0] inst_sel;
  logic [1:0]        frm;
  logic              ext_fields;
  logic              sel_in_range;

  // selector beyond range falls back to instance zero
  assign sel_in_range = (32'(resource_instance_select_i) < 32'(NUM_INST));

  always_comb
  begin
    inst_sel = '0;
    if (instance_selector_supported_i && sel_in_range)
    begin
      inst_sel = resource_instance_select_i; // see RULE_15
    end
  end
  assign frm = frame_i;
  // extension fields exist only beyond the base revision
  assign ext_fields = !BASE_REVISION && (REV_BYTE != pfid_pkg::REV_1P0);

  //////////////////////////////////////////////////////////////////////////////
  // capacity words, one per frame, each from its own field slice

  logic [31:0] cap_word [pfid_pkg::NUM_FRAMES];

  genvar g;
  generate
    for (g = 0; g < pfid_pkg::NUM_FRAMES; g++)
    begin : g_frame
      logic [31:0] idx;
      logic        softlim_sel;
      logic        max_absent_sel;
      logic        min_present_sel;
      logic        assoc_present_sel;
      logic [4:0]  assoc_wd_sel;
      logic [5:0]  max_wd_sel;

      assign idx = 32'(g) * 32'(NUM_INST) + 32'(inst_sel);

      // base revision reports none of the extension fields
      assign softlim_sel       = ext_fields & capacity_softlimit_present_i[idx];
      assign max_absent_sel    = ext_fields & capacity_max_absent_i[idx];
      assign min_present_sel   = ext_fields & capacity_min_present_i[idx];
      assign assoc_present_sel = ext_fields & associativity_max_present_i[idx];
      assign assoc_wd_sel      = ext_fields ? associativity_fraction_bits_i[idx*5 +: 5] : 5'h00;
      // fraction count is reported on every revision
      assign max_wd_sel        = capacity_fraction_bits_i[idx*6 +: 6];

      // each frame owns its copy, contents may differ; see RULE_05 see RULE_06
      pfid_cap_word u_cap
      (
        .softlim_i       (softlim_sel),
        .max_absent_i    (max_absent_sel),
        .min_present_i   (min_present_sel),
        .assoc_present_i (assoc_present_sel),
        .assoc_wd_i      (assoc_wd_sel),
        .max_wd_i        (max_wd_sel),
        .word_o          (cap_word[g])
      );
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////////
  // read decode

  logic        frame_ok;
  logic        rev_hit;
  logic        cap_hit;
  logic [31:0] cap_sel;
  logic [31:0] rdata_nxt;

  // root and fourth frames read zero unless that feature exists
  always_comb
  begin
    frame_ok = 1'b0;
    unique case (pfid_pkg::pfid_frame_type'(frm))
      pfid_pkg::PFID_FRAME_SECURE:
      begin
        frame_ok = 1'b1;
      end
      pfid_pkg::PFID_FRAME_NONSECURE:
      begin
        frame_ok = 1'b1;
      end
      pfid_pkg::PFID_FRAME_ROOT:
      begin
        frame_ok = fourth_space_feature_i; // see RULE_04
      end
      pfid_pkg::PFID_FRAME_FOURTH:
      begin
        frame_ok = fourth_space_feature_i; // see RULE_04
      end
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // offset decode

  // exact match only; any other offset in the frame reads zero
  assign rev_hit = (addr_i == pfid_pkg::ARCH_REV_OFFSET); // see RULE_03
  assign cap_hit = (addr_i == pfid_pkg::CAP_FEAT_OFFSET) &&
                   capacity_partitioning_present_i; // see RULE_07 see RULE_08

  //////////////////////////////////////////////////////////////////////////////
  // capacity copy select

  // frame code picks its own copy, never a shared one
  always_comb
  begin
    cap_sel = cap_word[pfid_pkg::PFID_FRAME_SECURE];
    unique case (pfid_pkg::pfid_frame_type'(frm))
      pfid_pkg::PFID_FRAME_SECURE:
      begin
        cap_sel = cap_word[pfid_pkg::PFID_FRAME_SECURE];
      end
      pfid_pkg::PFID_FRAME_NONSECURE:
      begin
        cap_sel = cap_word[pfid_pkg::PFID_FRAME_NONSECURE];
      end
      pfid_pkg::PFID_FRAME_ROOT:
      begin
        cap_sel = cap_word[pfid_pkg::PFID_FRAME_ROOT];
      end
      pfid_pkg::PFID_FRAME_FOURTH:
      begin
        cap_sel = cap_word[pfid_pkg::PFID_FRAME_FOURTH];
      end
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // read data

  always_comb
  begin
    rdata_nxt = pfid_pkg::RDATA_RESET;
    if (rd_i && frame_ok)
    begin
      if (rev_hit)
      begin
        rdata_nxt = rev_word; // see RULE_01 see RULE_02
      end
      else if (cap_hit)
      begin
        rdata_nxt = cap_sel;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // answer registers; writes have no path into state

  logic [31:0] rdata_r;
  logic        rvalid_r;

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      rdata_r <= pfid_pkg::RDATA_RESET;
    end
    else
    begin
      rdata_r <= rdata_nxt; // see RULE_19
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      rvalid_r <= 1'b0;
    end
    else
    begin
      rvalid_r <= rd_i;
    end
  end

  // write data deliberately unused: every register here is read-only
  logic unused_wr;
  assign unused_wr = wr_i ^ (^wdata_i);

  assign rdata_o  = rdata_r;
  assign rvalid_o = rvalid_r;

endmodule

// [test/pfid_regs_chk.sv]
/*
  checker for the pfid_regs read port.
  assumes a bind from the bench top.
*/
`timescale 1ns/100ps
module pfid_regs_chk
#(
  parameter int         NUM_INST = 1,
  parameter int         INST_W   = 1,
  parameter logic [7:0] REV_BYTE = pfid_pkg::REV_1P1
)
(
  input wire logic                  clk_i,
  input wire logic                  rst_n_i,
  input wire logic [1:0]            frame_i,
  input wire logic [11:0]           addr_i,
  input wire logic                  rd_i,
  input wire logic                  capacity_partitioning_present_i,
  input wire logic                  fourth_space_feature_i,
  input wire logic                  instance_selector_supported_i,
  input wire logic [INST_W-1:0]     resource_instance_select_i,
  input wire logic [4*NUM_INST-1:0] capacity_max_absent_i,
  input wire logic [4*NUM_INST*6-1:0] capacity_fraction_bits_i,
  input wire logic [31:0]           rdata_o,
  input wire logic                  rvalid_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  int   idx;
  logic live;
  logic cap_rd;
  // out-of-range instance handling not modelled here
  assign idx    = int'(frame_i) * NUM_INST
                  + (instance_selector_supported_i ? int'(resource_instance_select_i) : 0);
  assign live   = !frame_i[1] || fourth_space_feature_i;
  assign cap_rd = rd_i && addr_i == 12'h038 && capacity_partitioning_present_i && live;
  ////////////////////////////////////////////////////////////////////////////////
  a_read_answer: assert property (rd_i |=> rvalid_o)
    else $error("read not answered next cycle");
  a_idle_quiet: assert property (!rd_i |=> !rvalid_o && rdata_o == 32'h0)
    else $error("output active without a read");
  a_rev_same: assert property (rd_i && addr_i == 12'h020 && live |=> rdata_o == {24'h0, REV_BYTE})
    else $error("revision word wrong");
  a_fourth_off: assert property (rd_i && frame_i[1] && !fourth_space_feature_i |=> rdata_o == 32'h0)
    else $error("absent frame not zero");
  a_cap_off: assert property (rd_i && addr_i == 12'h038 && !capacity_partitioning_present_i |=> rdata_o == 32'h0)
    else $error("absent capacity word not zero");
  a_cap_rsvd: assert property (cap_rd |=> rdata_o[27:13] == 15'h0 && rdata_o[7:6] == 2'h0)
    else $error("capacity reserved bits set");
  a_cap_width: assert property (cap_rd |=> rdata_o[5:0] == $past(capacity_fraction_bits_i[6*idx +: 6]))
    else $error("capacity fraction count wrong");
  a_cap_maxabs: assert property (cap_rd |=> rdata_o[30] == $past(capacity_max_absent_i[idx]))
    else $error("maximum control absent bit wrong");
endmodule

// [test/tb_pfid_regs.sv]
/*
  bench for pfid_regs: reads every frame and instance, writes, absent features.
  assumes the design answers one cycle after each read strobe.
*/
`timescale 1ns/100ps
module tb_pfid_regs;
  logic        clk_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic [1:0]  frame_i = 2'h0;
  logic [11:0] addr_i = 12'h0;
  logic        rd_i = 1'b0;
  logic        wr_i = 1'b0;
  logic [31:0] wdata_i = 32'h0;
  logic        capacity_partitioning_present_i = 1'b1;
  logic        fourth_space_feature_i = 1'b1;
  logic        instance_selector_supported_i = 1'b1;
  logic [0:0]  resource_instance_select_i = 1'h0;
  logic [7:0]  capacity_softlimit_present_i, capacity_max_absent_i;
  logic [7:0]  capacity_min_present_i, associativity_max_present_i;
  logic [39:0] associativity_fraction_bits_i;
  logic [47:0] capacity_fraction_bits_i;
  logic [31:0] rdata_o;
  logic        rvalid_o;
  int          bad_count = 0;
  int          n_compared = 0;
  int          cycles = 0;
  always #50 clk_i = ~clk_i;
  pfid_regs #(.NUM_INST(2), .INST_W(1)) uut (.clk_i, .rst_n_i, .frame_i, .addr_i, .rd_i, .wr_i,
    .wdata_i, .capacity_partitioning_present_i, .fourth_space_feature_i,
    .instance_selector_supported_i, .resource_instance_select_i, .capacity_softlimit_present_i,
    .capacity_max_absent_i, .capacity_min_present_i, .associativity_max_present_i,
    .associativity_fraction_bits_i, .capacity_fraction_bits_i, .rdata_o, .rvalid_o);
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // strobe stays high so reads run back to back
  task automatic rd(input logic [1:0] f, input logic [11:0] a, input logic [31:0] exp);
    frame_i = f;
    addr_i = a;
    rd_i = 1'b1;
    @(posedge clk_i);
    #1;
    check("rvalid", {31'h0, rvalid_o}, 32'h1);
    check("rdata", rdata_o, exp);
  endtask
  task automatic idle();
    rd_i = 1'b0;
    @(posedge clk_i);
    #1;
    check("idle data", rdata_o, 32'h0);
    check("idle valid", {31'h0, rvalid_o}, 32'h0);
  endtask
  function automatic logic [31:0] cap_word(input int s);
    return {capacity_softlimit_present_i[s], capacity_max_absent_i[s], capacity_min_present_i[s],
      associativity_max_present_i[s], 15'h0, associativity_fraction_bits_i[5*s +: 5], 2'h0,
      capacity_fraction_bits_i[6*s +: 6]};
  endfunction
  task automatic t_rev();
    for (int f = 0; f < 4; f++)
      rd(2'(f), 12'h020, 32'h11);
    fourth_space_feature_i = 1'b0;
    rd(2'h3, 12'h020, 32'h0);
    rd(2'h2, 12'h038, 32'h0);
    fourth_space_feature_i = 1'b1;
  endtask
  task automatic t_cap();
    for (int s = 0; s < 8; s++)
    begin
      resource_instance_select_i = 1'(s);
      rd(2'(s / 2), 12'h038, cap_word(s));
    end
    instance_selector_supported_i = 1'b0;
    rd(2'h1, 12'h038, cap_word(2));
    capacity_partitioning_present_i = 1'b0;
    rd(2'h0, 12'h038, 32'h0);
    capacity_partitioning_present_i = 1'b1;
    idle();
  endtask
  task automatic t_write();
    instance_selector_supported_i = 1'b1;
    resource_instance_select_i = 1'h0;
    frame_i = 2'h1;
    wr_i = 1'b1;
    wdata_i = 32'hffff_ffff;
    addr_i = 12'h020;
    @(posedge clk_i);
    #1;
    addr_i = 12'h038;
    @(posedge clk_i);
    #1;
    wr_i = 1'b0;
    check("write answer", {31'h0, rvalid_o}, 32'h0);
    check("write data", rdata_o, 32'h0);
    rd(2'h1, 12'h020, 32'h11);
    rd(2'h1, 12'h038, cap_word(2));
    rd(2'h1, 12'h024, 32'h0);
    idle();
  endtask
  // reset in mid-run drops a pending answer at once
  task automatic t_reset();
    frame_i = 2'h1;
    addr_i = 12'h020;
    rd_i = 1'b1;
    @(posedge clk_i);
    #1;
    rd_i = 1'b0;
    rst_n_i = 1'b0;
    #1;
    check("reset data", rdata_o, 32'h0);
    check("reset valid", {31'h0, rvalid_o}, 32'h0);
    @(posedge clk_i);
    #1;
    rst_n_i = 1'b1;
    rd(2'h2, 12'h038, cap_word(4));
    idle();
  endtask
  task automatic final_report();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      bad_count++;
      final_report();
    end
  end
  initial
  begin
    for (int s = 0; s < 8; s++)
    begin
      capacity_softlimit_present_i[s] = s[0];
      capacity_max_absent_i[s] = s[1];
      capacity_min_present_i[s] = s[2];
      associativity_max_present_i[s] = ~s[0];
      associativity_fraction_bits_i[5*s +: 5] = 5'(s + 3);
      capacity_fraction_bits_i[6*s +: 6] = 6'(2 * s + 2); // top slice hits 16
    end
    repeat (2) @(posedge clk_i);
    #1;
    rst_n_i = 1'b1;
    t_rev();
    t_cap();
    t_write();
    t_reset();
    final_report();
  end
endmodule
bind pfid_regs pfid_regs_chk #(.NUM_INST(NUM_INST), .INST_W(INST_W), .REV_BYTE(REV_BYTE)) u_chk
  (.clk_i, .rst_n_i, .frame_i, .addr_i, .rd_i, .capacity_partitioning_present_i,
  .fourth_space_feature_i, .instance_selector_supported_i, .resource_instance_select_i,
  .capacity_max_absent_i, .capacity_fraction_bits_i, .rdata_o, .rvalid_o);
